/* File: loop_diag_pkg.sv */
// Purpose: shared constants for the loop detector diagnostics block
// Assumes: AHB-Lite register bus, 32-bit words, 10 MHz core clock
// Notes:   offsets are byte addresses of aligned words
package loop_diag_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_DEV_FLAGS   = 8'h00;
  localparam logic [7:0] OFS_CAN_ADDR    = 8'h04;
  localparam logic [7:0] OFS_LED_TIME    = 8'h08;
  localparam logic [7:0] OFS_MEAS_TIME   = 8'h0C;
  localparam logic [7:0] OFS_CMD         = 8'h10;
  localparam logic [7:0] OFS_CLASS_EN    = 8'h14;
  localparam logic [7:0] OFS_THR_ON01    = 8'h18;
  localparam logic [7:0] OFS_THR_ON23    = 8'h1C;
  localparam logic [7:0] OFS_THR_CL      = 8'h20;
  localparam logic [7:0] OFS_OVS         = 8'h24;
  localparam logic [7:0] OFS_IND_SEL     = 8'h28;
  localparam logic [7:0] OFS_CH_STATUS   = 8'h2C;
  localparam logic [7:0] OFS_ALIGN_TOT   = 8'h30;
  localparam logic [7:0] OFS_ALIGN_HTE   = 8'h34;
  localparam logic [7:0] OFS_ALIGN_CAUSE = 8'h38;
  localparam logic [7:0] OFS_MAX01       = 8'h3C;
  localparam logic [7:0] OFS_MAX23       = 8'h40;
  localparam logic [7:0] OFS_LAST01      = 8'h44;
  localparam logic [7:0] OFS_LAST23      = 8'h48;
  localparam logic [7:0] OFS_IND         = 8'h4C;
  localparam logic [7:0] OFS_RESET_INFO  = 8'h50;
  localparam logic [7:0] OFS_CYCLE       = 8'h54;
  localparam logic [7:0] OFS_BIT_TIME    = 8'h58;
  localparam logic [7:0] OFS_ADDR_STAT   = 8'h5C;

  // ------------------------------------------------------------
  // field positions, reset values, OVS clamp and inductance step
  // ------------------------------------------------------------
  localparam int          FLAG_SYNC_MASTER = 0;
  localparam int          FLAG_HW_ADDR     = 1;
  localparam int          CMD_CNT_CLEAR    = 0;
  localparam int          RST_BIT_FLAG     = 0;
  localparam logic [1:0]  FLAGS_RST        = 2'h2;
  localparam logic [15:0] BIT_MIN_RST      = 16'hFFFF;
  localparam logic [2:0]  OVS_MAX_CODE     = 3'h4;
  localparam logic [15:0] IND_STEP_UH      = 16'h000A;

  // ------------------------------------------------------------
  // alignment cause codes
  // ------------------------------------------------------------
  localparam logic [2:0] CAUSE_NONE   = 3'h0;
  localparam logic [2:0] CAUSE_RANGE  = 3'h1;
  localparam logic [2:0] CAUSE_LINKED = 3'h2;
  localparam logic [2:0] CAUSE_HOLD   = 3'h3;
  localparam logic [2:0] CAUSE_USER   = 3'h4;
  localparam logic [2:0] CAUSE_SYNC   = 3'h5;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LED_UNIT_NS   = 1000000;
  localparam int MS_TICKS      = LED_UNIT_NS / CLK_PERIOD_NS;
endpackage : loop_diag_pkg

/* File: loop_diag.sv */
// Purpose: diagnostics, LED timer, addressing and classification of a
//          four-channel loop detector, with an AHB-Lite register slave
// Assumes: amplitude samples and alignment events come from the
//          measurement core on the same clock; pins are asynchronous
// Notes:   reads take one wait state, writes none; response always OKAY
`timescale 1ns/1ps

module loop_diag
  import loop_diag_pkg::*;
#(
  parameter int MS_TICKS_P = MS_TICKS
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic      [31:0]      o_hrdata,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  input  wire logic [3:0]       i_amp_valid,
  input  wire logic [3:0][15:0] i_amp,
  input  wire logic [3:0][15:0] i_ind_uh,
  input  wire logic [3:0]       i_ch_error,
  input  wire logic [3:0]       i_align_evt,
  input  wire logic [3:0][2:0]  i_align_cause,
  input  wire logic             i_sync_active,
  input  wire logic [3:0][7:0]  i_peer_meas,
  input  wire logic             i_reset_evt,
  input  wire logic [7:0]       i_reset_cause,
  input  wire logic             i_svc_activity,
  input  wire logic             i_button,
  input  wire logic             i_can_rx,
  input  wire logic [2:0]       i_addr_sw,
  output logic      [3:0]       o_sw_out,
  output logic      [3:0]       o_led,
  output logic      [3:0]       o_can_occ,
  output logic      [1:0]       o_class_byte7,
  output logic      [5:0]       o_can_addr,
  output logic                  o_can_en,
  output logic                  o_sync_master,
  output logic                  o_det_reset
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic            hready;
    logic [31:0]     hrdata;
    logic            hresp;
    logic            rd_pend;
    logic            wr_pend;
    logic [7:0]      addr;
    logic [1:0]      flags;
    logic [5:0]      can_addr;
    logic [15:0]     led_time;
    logic [3:0][7:0] meas;
    logic [1:0]      class_en;
    logic [3:0][15:0] thr_on;
    logic [1:0][15:0] thr_cl;
    logic [3:0][2:0] ovs;
    logic [1:0]      ind_sel;
    logic            det_reset;
    logic [5:0]      out_addr;
    logic            can_en;
    logic            led_on;
    logic [15:0]     led_cnt;
    logic [15:0]     ms_cnt;
    logic [3:0][4:0] ovs_cnt;
    logic [3:0][19:0] acc;
    logic [3:0]      occ;
    logic [1:0]      cls;
    logic [1:0]      cls_byte;
    logic [3:0][15:0] peak;
    logic [3:0][15:0] last;
    logic [3:0][15:0] maxa;
    logic [3:0]      err;
    logic [3:0]      err_hist;
    logic [3:0][7:0] al_tot;
    logic [3:0][7:0] al_hte;
    logic [3:0][2:0] al_cause;
    logic [7:0]      rst_cnt;
    logic [7:0]      rst_cause;
    logic [15:0]     cycle;
    logic [2:0]      rx_sync;
    logic [2:0]      btn_sync;
    logic [2:0][2:0] sw_sync;
    logic            rx_level;
    logic            btn_level;
    logic [2:0]      sw_level;
    logic [15:0]     rx_run;
    logic [15:0]     bit_min;
    logic [3:0]      outs;
    logic [3:0]      leds;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] rdata;
    logic        clr;
    logic        press;
    logic        hw_on;
    logic        on;
    logic [19:0] sum;
    logic [15:0] avg;
    logic [15:0] ind;
    logic [7:0]  mt;
    rdata = 32'h0000_0000;
    clr   = 1'b0;
    press = 1'b0;
    hw_on = 1'b0;
    on    = 1'b0;
    sum   = 20'h0_0000;
    avg   = 16'h0000;
    ind   = 16'h0000;
    mt    = 8'h00;
    state_next           = state_reg;
    state_next.hresp     = 1'b0;
    state_next.det_reset = 1'b0;
    state_next.wr_pend   = 1'b0;

    // pin synchronisers: a change counts once second and third stages agree
    state_next.rx_sync  = {state_reg.rx_sync[1:0], i_can_rx};
    state_next.btn_sync = {state_reg.btn_sync[1:0], i_button};
    state_next.sw_sync  = {state_reg.sw_sync[1:0], i_addr_sw};
    if (state_reg.rx_sync[1] == state_reg.rx_sync[2]) begin
      state_next.rx_level = state_reg.rx_sync[2];
    end
    if (state_reg.btn_sync[1] == state_reg.btn_sync[2]) begin
      state_next.btn_level = state_reg.btn_sync[2];
    end
    if (state_reg.sw_sync[1] == state_reg.sw_sync[2]) begin
      state_next.sw_level = state_reg.sw_sync[2];
    end
    press = state_next.btn_level & ~state_reg.btn_level;

    // register writes land in the data phase
    if (state_reg.wr_pend) begin
      if (state_reg.addr == OFS_DEV_FLAGS) begin
        state_next.flags = i_hwdata[1:0];
        if (i_hwdata[FLAG_HW_ADDR] != state_reg.flags[FLAG_HW_ADDR]) begin
          state_next.det_reset = 1'b1;
        end
      end else if (state_reg.addr == OFS_CAN_ADDR) begin
        state_next.can_addr = i_hwdata[5:0];
      end else if (state_reg.addr == OFS_LED_TIME) begin
        state_next.led_time = i_hwdata[15:0];
      end else if (state_reg.addr == OFS_MEAS_TIME) begin
        state_next.meas = i_hwdata;
      end else if (state_reg.addr == OFS_CMD) begin
        clr = i_hwdata[CMD_CNT_CLEAR];
      end else if (state_reg.addr == OFS_CLASS_EN) begin
        state_next.class_en = i_hwdata[1:0];
      end else if (state_reg.addr == OFS_THR_ON01) begin
        state_next.thr_on[1:0] = i_hwdata;
      end else if (state_reg.addr == OFS_THR_ON23) begin
        state_next.thr_on[3:2] = i_hwdata;
      end else if (state_reg.addr == OFS_THR_CL) begin
        state_next.thr_cl = i_hwdata;
      end else if (state_reg.addr == OFS_OVS) begin
        for (int i = 0; i < 4; i++) begin
          mt = i_hwdata[i*8 +: 8];
          state_next.ovs[i] = (mt > 8'(OVS_MAX_CODE)) ? OVS_MAX_CODE : mt[2:0];
        end
      end else if (state_reg.addr == OFS_IND_SEL) begin
        state_next.ind_sel = i_hwdata[1:0];
      end
    end

    // counter reset first, so an event in the same cycle still counts
    if (clr) begin
      state_next.al_tot    = '0;
      state_next.al_hte    = '0;
      state_next.al_cause  = '0;
      state_next.last      = '0;
      state_next.maxa      = '0;
      state_next.rst_cnt   = 8'h00;
      state_next.rst_cause = 8'h00;
    end

    // reset bookkeeping
    if (state_next.det_reset || i_reset_evt) begin
      state_next.rst_cnt   = state_next.rst_cnt + 8'h01;
      state_next.rst_cause = (i_reset_evt ? i_reset_cause : 8'h00) |
                             (state_next.det_reset ? 8'h01 << RST_BIT_FLAG : 8'h00);
    end

    // CAN addressing: switches win while enabled and non-zero
    // registered flag, so the address follows the flag and switches one cycle later
    hw_on = state_reg.flags[FLAG_HW_ADDR] && (state_reg.sw_level != 3'h0);
    state_next.out_addr = hw_on ? {3'h0, state_reg.sw_level} : state_next.can_addr;
    state_next.can_en   = (state_next.out_addr != 6'h00);

    // LED idle timer in millisecond ticks
    if (state_reg.ms_cnt == 16'(MS_TICKS_P - 1)) begin
      state_next.ms_cnt = 16'h0000;
    end else begin
      state_next.ms_cnt = state_reg.ms_cnt + 16'h0001;
    end
    if (press || i_svc_activity) begin
      state_next.led_on  = 1'b1;
      state_next.led_cnt = 16'h0000;
    end else if (state_next.led_time == 16'h0000) begin
      state_next.led_on  = 1'b1;
      state_next.led_cnt = 16'h0000;
    end else if (state_reg.led_on && state_reg.ms_cnt == 16'(MS_TICKS_P - 1)) begin
      state_next.led_cnt = state_reg.led_cnt + 16'h0001;
      if (state_next.led_cnt >= state_next.led_time) begin
        state_next.led_on = 1'b0;
      end
    end

    // per-channel status, alignment and amplitude tracking
    state_next.err = i_ch_error;
    for (int i = 0; i < 4; i++) begin
      if (i_ch_error[i]) begin
        state_next.err_hist[i] = 1'b1;
      end
      if (i_align_evt[i]) begin
        state_next.al_tot[i]   = state_next.al_tot[i] + 8'h01;
        state_next.al_cause[i] = i_align_cause[i];
        state_next.maxa[i]     = 16'h0000;
        if (i_align_cause[i] == CAUSE_HOLD) begin
          state_next.al_hte[i] = state_next.al_hte[i] + 8'h01;
        end
      end
      if (i_amp_valid[i]) begin
        sum = state_reg.acc[i] + {4'h0, i_amp[i]};
        state_next.ovs_cnt[i] = state_reg.ovs_cnt[i] + 5'h01;
        state_next.acc[i]     = sum;
        if (state_next.ovs_cnt[i] == (5'h01 << state_reg.ovs[i])) begin
          avg = 16'(sum >> state_reg.ovs[i]);
          state_next.ovs_cnt[i] = 5'h00;
          state_next.acc[i]     = 20'h0_0000;
          on = avg > state_reg.thr_on[i];
          if (on) begin
            state_next.occ[i] = 1'b1;
            if (avg > state_reg.peak[i]) begin
              state_next.peak[i] = avg;
            end
            if (i < 2) begin
              if (!state_reg.occ[i]) begin
                state_next.cls_byte[i % 2] = 1'b0;
              end
              if (state_reg.class_en[i % 2] && avg > state_reg.thr_cl[i % 2]) begin
                state_next.cls[i % 2]      = 1'b1;
                state_next.cls_byte[i % 2] = 1'b1;
              end
            end
          end else begin
            if (state_reg.occ[i]) begin
              state_next.last[i] = state_reg.peak[i];
              if (state_reg.peak[i] > state_next.maxa[i]) begin
                state_next.maxa[i] = state_reg.peak[i];
              end
            end
            state_next.occ[i]  = 1'b0;
            state_next.peak[i] = 16'h0000;
            if (i < 2) begin
              state_next.cls[i % 2] = 1'b0;
            end
          end
        end
      end
    end

    // outputs 3/4 carry the class result when channel 1/2 classifies
    for (int i = 0; i < 4; i++) begin
      if (i >= 2 && state_next.class_en[i % 2]) begin
        state_next.outs[i] = state_next.cls[i % 2];
      end else begin
        state_next.outs[i] = state_next.occ[i];
      end
    end
    state_next.leds = state_next.led_on ? state_next.outs : 4'h0;

    // cycle time, peers widen each position when synchronised
    state_next.cycle = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      mt = state_next.meas[i];
      if (i_sync_active && i_peer_meas[i] > mt) begin
        mt = i_peer_meas[i];
      end
      state_next.cycle = state_next.cycle + {8'h00, mt};
    end

    // bit time: shortest low run seen on the bus
    if (!state_reg.rx_level) begin
      if (state_reg.rx_run != 16'hFFFF) begin
        state_next.rx_run = state_reg.rx_run + 16'h0001;
      end
    end else if (state_reg.rx_run != 16'h0000) begin
      if (state_reg.rx_run < state_reg.bit_min) begin
        state_next.bit_min = state_reg.rx_run;
      end
      state_next.rx_run = 16'h0000;
    end

    // read data is built in the wait state, after any pending write
    ind = (i_ind_uh[state_reg.ind_sel] / IND_STEP_UH) * IND_STEP_UH;
    if (state_reg.addr == OFS_DEV_FLAGS) begin
      rdata = {30'h0, state_reg.flags};
    end else if (state_reg.addr == OFS_CAN_ADDR) begin
      rdata = {26'h0, state_reg.can_addr};
    end else if (state_reg.addr == OFS_LED_TIME) begin
      rdata = {16'h0000, state_reg.led_time};
    end else if (state_reg.addr == OFS_MEAS_TIME) begin
      rdata = state_reg.meas;
    end else if (state_reg.addr == OFS_CLASS_EN) begin
      rdata = {30'h0, state_reg.class_en};
    end else if (state_reg.addr == OFS_THR_ON01) begin
      rdata = state_reg.thr_on[1:0];
    end else if (state_reg.addr == OFS_THR_ON23) begin
      rdata = state_reg.thr_on[3:2];
    end else if (state_reg.addr == OFS_THR_CL) begin
      rdata = state_reg.thr_cl;
    end else if (state_reg.addr == OFS_OVS) begin
      for (int i = 0; i < 4; i++) begin
        rdata[i*8 +: 8] = {5'h00, state_reg.ovs[i]};
      end
    end else if (state_reg.addr == OFS_IND_SEL) begin
      rdata = {30'h0, state_reg.ind_sel};
    end else if (state_reg.addr == OFS_CH_STATUS) begin
      for (int i = 0; i < 4; i++) begin
        rdata[i*4 +: 4] = {1'b0, state_reg.err_hist[i], state_reg.err[i], state_reg.occ[i]};
      end
    end else if (state_reg.addr == OFS_ALIGN_TOT) begin
      rdata = state_reg.al_tot;
    end else if (state_reg.addr == OFS_ALIGN_HTE) begin
      rdata = state_reg.al_hte;
    end else if (state_reg.addr == OFS_ALIGN_CAUSE) begin
      for (int i = 0; i < 4; i++) begin
        rdata[i*8 +: 8] = {5'h00, state_reg.al_cause[i]};
      end
    end else if (state_reg.addr == OFS_MAX01) begin
      rdata = state_reg.maxa[1:0];
    end else if (state_reg.addr == OFS_MAX23) begin
      rdata = state_reg.maxa[3:2];
    end else if (state_reg.addr == OFS_LAST01) begin
      rdata = state_reg.last[1:0];
    end else if (state_reg.addr == OFS_LAST23) begin
      rdata = state_reg.last[3:2];
    end else if (state_reg.addr == OFS_IND) begin
      rdata = {16'h0000, ind};
    end else if (state_reg.addr == OFS_RESET_INFO) begin
      rdata = {16'h0000, state_reg.rst_cnt, state_reg.rst_cause};
    end else if (state_reg.addr == OFS_CYCLE) begin
      rdata = {16'h0000, state_reg.cycle};
    end else if (state_reg.addr == OFS_BIT_TIME) begin
      rdata = {16'h0000, state_reg.bit_min};
    end else if (state_reg.addr == OFS_ADDR_STAT) begin
      rdata = {24'h0, 1'b0, state_reg.can_en, state_reg.out_addr};
    end
    if (state_reg.rd_pend) begin
      state_next.hrdata  = rdata;
      state_next.hready  = 1'b1;
      state_next.rd_pend = 1'b0;
    end

    // address phase: reads stall one cycle, writes go straight through
    if (i_hsel && i_htrans[1] && i_hready) begin
      state_next.addr    = i_haddr[7:0];
      state_next.wr_pend = i_hwrite;
      state_next.rd_pend = !i_hwrite;
      state_next.hready  = i_hwrite;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg         <= '0;
      state_reg.hready  <= 1'b1;
      state_reg.flags   <= FLAGS_RST;
      state_reg.led_on  <= 1'b1;
      state_reg.bit_min <= BIT_MIN_RST;
      // bus idles recessive; a low reset level would fake a short run
      state_reg.rx_sync  <= 3'h7;
      state_reg.rx_level <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_hrdata      = state_reg.hrdata;
  assign o_hreadyout   = state_reg.hready;
  assign o_hresp       = state_reg.hresp;
  assign o_sw_out      = state_reg.outs;
  assign o_can_occ     = state_reg.outs;
  assign o_led         = state_reg.leds;
  assign o_class_byte7 = state_reg.cls_byte;
  assign o_can_addr    = state_reg.out_addr;
  assign o_can_en      = state_reg.can_en;
  assign o_sync_master = state_reg.flags[FLAG_SYNC_MASTER];
  assign o_det_reset   = state_reg.det_reset;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // counter-clear strobe, excluded from the hold-time count check
  logic clr_w;
  assign clr_w = state_reg.wr_pend && state_reg.addr == OFS_CMD && i_hwdata[CMD_CNT_CLEAR];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  flag_reset_a: assert property ($changed(state_reg.flags[FLAG_HW_ADDR]) |-> o_det_reset)
    else $error("hw address flag changed without detector reset");
  led_idle_a: assert property (state_reg.led_time == 16'h0000 |=> state_reg.led_on)
    else $error("LEDs off with zero interval");
  led_wake_a: assert property (i_svc_activity |=> state_reg.led_on && state_reg.led_cnt == 0)
    else $error("service traffic did not wake LEDs");
  hist_sticky_a: assert property (i_ch_error[1] |=> state_reg.err_hist[1] [*3])
    else $error("error history not sticky");
  hte_count_a: assert property (i_align_evt[1] && i_align_cause[1] == CAUSE_HOLD && !clr_w
      |=> state_reg.al_hte[1] == $past(state_reg.al_hte[1]) + 8'h01 &&
          state_reg.al_tot[1] == $past(state_reg.al_tot[1]) + 8'h01)
    else $error("hold time alignment not counted twice");
  class_release_a: assert property ($fell(state_reg.occ[0]) |-> !state_reg.cls[0])
    else $error("class output outlived passage");
  max_amp_a: assert property ($fell(state_reg.occ[0]) |-> state_reg.maxa[0] >= state_reg.last[0])
    else $error("maximum below last amplitude");
  hw_addr_a: assert property (state_reg.flags[FLAG_HW_ADDR] && state_reg.sw_level == 3'h5
      |=> o_can_addr == 6'h05 && o_can_en)
    else $error("switch address not applied");
  cycle_sum_a: assert property (!i_sync_active |=> state_reg.cycle ==
      {8'h00, state_reg.meas[0]} + {8'h00, state_reg.meas[1]} +
      {8'h00, state_reg.meas[2]} + {8'h00, state_reg.meas[3]})
    else $error("cycle time not sum of measuring times");
  read_wait_a: assert property (state_reg.rd_pend |-> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");

endmodule : loop_diag

/* File: can_partner.sv */
// Purpose: far side, CAN master traffic and service tool activity
// Assumes: bus idles recessive high between frames
// Notes:   shortest dominant run is BIT clocks
`timescale 1ns/1ps
module can_partner #(
  parameter int BIT = 6
) (
  input  wire logic i_core_clk,
  input  wire logic i_go,
  output logic      o_rx,
  output logic      o_svc
);
  // ----------------------------------------
  // frames of growing bit length, then a poke
  // ----------------------------------------
  initial begin
    o_rx = 1'b1;
    o_svc = 1'b0;
    wait (i_go);
    for (int k = 1; k < 4; k++) begin
      repeat (BIT * k) @(posedge i_core_clk) o_rx <= 1'b0;
      repeat (BIT * k) @(posedge i_core_clk) o_rx <= 1'b1;
    end
    @(posedge i_core_clk) o_svc <= 1'b1;
    @(posedge i_core_clk) o_svc <= 1'b0;
  end
endmodule : can_partner

/* File: loop_diag_tb.sv */
// Purpose: self-checking bench for loop_diag
// Assumes: ms prescaler cut to 4 clocks so timers stay short
// Notes:   expectations come from integer models here
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("Error %0t %h %h", $time, a, b); end end
module loop_diag_tb
  import loop_diag_pkg::*;
;
  logic i_core_clk = 0, i_reset_n = 0, i_hsel = 0, i_hwrite = 0, i_sync_active = 0;
  logic i_reset_evt = 0, i_button = 0, go = 0, i_can_rx, i_svc_activity;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd;
  logic [2:0] i_hsize = 3'h2, i_addr_sw = 0;
  logic [1:0] i_htrans = 0, o_class_byte7;
  logic [3:0] i_amp_valid = 0, i_ch_error = 0, i_align_evt = 0, o_sw_out, o_led, o_can_occ;
  logic [3:0][15:0] i_amp = 0, i_ind_uh = 0;
  logic [3:0][2:0] i_align_cause = 0;
  logic [3:0][7:0] i_peer_meas = 0;
  logic [7:0] i_reset_cause = 0;
  logic [5:0] o_can_addr;
  logic o_hreadyout, o_hresp, o_can_en, o_sync_master, o_det_reset;
  wire i_hready = o_hreadyout;
  int fails = 0, checks_done = 0, seed = 99, c = 0, a;
  int amps[$] = '{32, 80, 48, 16};
  loop_diag #(.MS_TICKS_P(4)) uut (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_amp_valid(i_amp_valid), .i_amp(i_amp), .i_ind_uh(i_ind_uh), .i_ch_error(i_ch_error),
    .i_align_evt(i_align_evt), .i_align_cause(i_align_cause), .i_sync_active(i_sync_active),
    .i_peer_meas(i_peer_meas), .i_reset_evt(i_reset_evt), .i_reset_cause(i_reset_cause),
    .i_svc_activity(i_svc_activity), .i_button(i_button), .i_can_rx(i_can_rx),
    .i_addr_sw(i_addr_sw), .o_sw_out(o_sw_out), .o_led(o_led), .o_can_occ(o_can_occ),
    .o_class_byte7(o_class_byte7), .o_can_addr(o_can_addr), .o_can_en(o_can_en),
    .o_sync_master(o_sync_master), .o_det_reset(o_det_reset));
  can_partner #(.BIT(6)) peer (.i_core_clk(i_core_clk), .i_go(go), .o_rx(i_can_rx),
    .o_svc(i_svc_activity));
  initial forever #50 i_core_clk = ~i_core_clk;
  // ----------------------------------------
  // bus cycles: hold each phase until ready
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    i_hsel <= 1'b1; i_haddr <= {24'h0, ad}; i_hwrite <= w; i_htrans <= 2'h2;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0; i_hwdata <= d;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    `CK({o_hresp, rd}, {1'b0, e})
  endtask : rchk
  task automatic meas(input int ch, input logic [15:0] v);
    i_amp[ch] <= v; i_amp_valid <= 4'h1 << ch;
    @(posedge i_core_clk) i_amp_valid <= 4'h0;
    @(posedge i_core_clk);
  endtask : meas
  task automatic stop_test;
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    stop_test();
  end
  // main sequence, one scenario after another
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    rchk(OFS_DEV_FLAGS, {30'h0, FLAGS_RST});
    rchk(OFS_LED_TIME, 32'h0);
    rchk(8'hFC, 32'h0);
    i_reset_cause <= 8'h04; i_reset_evt <= 1'b1;
    @(posedge i_core_clk) i_reset_evt <= 1'b0;
    rchk(OFS_RESET_INFO, 32'h0104);
    bus(1, OFS_CLASS_EN, 32'h1); bus(1, OFS_THR_ON01, 32'h00100010);
    bus(1, OFS_THR_CL, 32'h00400040);
    foreach (amps[i]) begin // strict compare, class output sticky per passage
      meas(0, 16'(amps[i]));
      c = int'(amps[i] > 16 && (c != 0 || amps[i] > 64));
      `CK(o_sw_out[0], 1'(amps[i] > 16))
      `CK(o_can_occ[0], 1'(amps[i] > 16))
      `CK(o_sw_out[2], 1'(c))
    end
    `CK(o_class_byte7[0], 1'b1)
    rchk(OFS_LAST01, 32'h50);
    rchk(OFS_MAX01, 32'h50);
    i_ch_error <= 4'h2; repeat (2) @(posedge i_core_clk);
    rchk(OFS_CH_STATUS, 32'h60);
    i_ch_error <= 4'h0; repeat (2) @(posedge i_core_clk);
    rchk(OFS_CH_STATUS, 32'h40);
    i_align_cause <= {3'h0, 3'h0, CAUSE_HOLD, CAUSE_USER}; i_align_evt <= 4'h3;
    @(posedge i_core_clk) i_align_evt <= 4'h0;
    rchk(OFS_ALIGN_TOT, 32'h0101);
    rchk(OFS_ALIGN_HTE, 32'h0100);
    rchk(OFS_ALIGN_CAUSE, 32'h0304);
    bus(1, OFS_CMD, 32'h1);
    rchk(OFS_ALIGN_TOT, 32'h0);
    rchk(OFS_RESET_INFO, 32'h0);
    a = $random(seed); c = 0; i_ind_uh <= {4{16'(a)}};
    for (int i = 0; i < 4; i++) c += (a >> (8 * i)) & 255;
    bus(1, OFS_MEAS_TIME, a);
    rchk(OFS_CYCLE, c);
    rchk(OFS_IND, (a & 32'hFFFF) / IND_STEP_UH * IND_STEP_UH);
    i_peer_meas <= 32'h00FF00FF; i_sync_active <= 1'b1;
    rchk(OFS_CYCLE, c + 510 - (a & 255) - ((a >> 16) & 255));
    i_sync_active <= 1'b0;
    bus(1, OFS_DEV_FLAGS, 32'h1); @(posedge i_core_clk);
    `CK(o_det_reset, 1'b1)
    @(posedge i_core_clk);
    `CK(o_sync_master, 1'b1)
    bus(1, OFS_CAN_ADDR, 32'h5); repeat (2) @(posedge i_core_clk);
    `CK({o_can_en, o_can_addr}, 7'h45)
    bus(1, OFS_CAN_ADDR, 32'h0); repeat (2) @(posedge i_core_clk);
    `CK(o_can_en, 1'b0)
    i_addr_sw <= 3'h5; bus(1, OFS_DEV_FLAGS, 32'h2); repeat (6) @(posedge i_core_clk);
    `CK({o_can_en, o_can_addr}, 7'h45)
    meas(0, 16'h20); repeat (30) @(posedge i_core_clk);
    `CK(o_led[0], 1'b1)
    bus(1, OFS_LED_TIME, 32'h2); repeat (30) @(posedge i_core_clk);
    `CK(o_led, 4'h0)
    go <= 1'b1;
    @(posedge i_svc_activity); repeat (3) @(posedge i_core_clk);
    `CK(o_led[0], 1'b1)
    repeat (30) @(posedge i_core_clk);
    `CK(o_led, 4'h0)
    i_button <= 1'b1; repeat (6) @(posedge i_core_clk);
    `CK(o_led[0], 1'b1)
    i_button <= 1'b0;
    rchk(OFS_BIT_TIME, 32'h6);
    stop_test();
  end
endmodule : loop_diag_tb
